// ---- inc/apc_pkg.sv ----
// constants and types shared by the converter end and the capture controller end
package apc_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // data path
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned IDX_W   = 11;
  localparam int unsigned WCNT_W  = 13;
  localparam int unsigned ENTRY_W = DATA_W + IDX_W + 1;

  // block sizes in words
  localparam logic [WCNT_W-1:0] SAMPLES_PER_BLOCK = 13'h0800;
  localparam logic [WCNT_W-1:0] BUFFER_LENGTH     = 13'h0800;
  localparam logic [WCNT_W-1:0] CAPTURE_TOTAL     = 13'(2 * BUFFER_LENGTH);

  // results to drop after enable: trim conversions plus the stale first read
  localparam logic [2:0] TRIM_CONVERSIONS = 3'h3;
  localparam logic [2:0] STALE_READS      = 3'h1;
  localparam logic [2:0] DISCARD_LEAD     = 3'(TRIM_CONVERSIONS + STALE_READS);

  // pin timing
  localparam int unsigned QUIET_NS      = 125;
  localparam logic [7:0]  QUIET_CYC     = 8'((QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned IO_WINDOW_NS  = 400;
  localparam logic [7:0]  IO_WINDOW_CYC = 8'(IO_WINDOW_NS / CLK_PERIOD_NS);
  localparam int unsigned CONVST_LOW_NS = 40;
  localparam logic [7:0]  CONVST_LOW_CYC =
    8'((CONVST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RD_LOW_NS     = 40;
  localparam logic [7:0]  RD_LOW_CYC    = 8'((RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned CONV_TIME_NS  = 1000;
  localparam logic [7:0]  CONV_CYC      = 8'(CONV_TIME_NS / CLK_PERIOD_NS);

  // sample rate timer
  localparam int unsigned TIMER_DIV        = 4;
  localparam logic [1:0]  TIMER_DIV_LAST   = 2'(TIMER_DIV - 1);
  localparam logic [1:0]  PULSE_TIMER_CLKS = 2'h2;

  // two-entry output buffer
  localparam logic [1:0] FIFO_FULL = 2'h2;

  // state types
  typedef enum logic {CV_SAMPLE, CV_CONVERT} apc_conv_st_t;
  typedef enum logic {RS_IDLE, RS_RUN} apc_run_st_t;
  typedef enum logic {SQ_IDLE, SQ_LOW} apc_seq_st_t;

endpackage

// ---- inc/apc_if.sv ----
// pin bundle between the capture controller and the converter
`timescale 1ns/10ps
`default_nettype none
interface apc_if;
  logic        convst_n;
  logic        cs_n;
  logic        rd_n;
  logic        byte_sel;
  logic        busy;
  logic [15:0] data;

  modport ctrl (output convst_n, output cs_n, output rd_n, output byte_sel,
                input busy, input data);
  modport conv (input convst_n, input cs_n, input rd_n, input byte_sel,
                output busy, output data);
endinterface
`default_nettype wire

// ---- rtl/apc_conv.sv ----
// converter end: sample/hold, conversion timing, internal reset and result latch
`timescale 1ns/10ps
`default_nettype none
module apc_conv
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic               SYS_CLK_I,
  input  wire logic               RESET_N_I,
  // pins
  apc_if.conv                     BUS,
  // user side
  input  wire logic [DATA_W-1:0]  SAMPLE_I,
  output var  logic               TRIM_DONE_O,
  output var  logic               RESET_EVENT_O
);

  apc_conv_st_t      st_r,      st_nxt;
  logic [7:0]        cnt_r,     cnt_nxt;
  logic [DATA_W-1:0] hold_r,    hold_nxt;
  logic [DATA_W-1:0] latch_r,   latch_nxt;
  logic [DATA_W-1:0] data_r,    data_nxt;
  logic [1:0]        trim_r,    trim_nxt;
  logic              busy_r,    busy_nxt;
  logic              cv_q_r,    cv_q_nxt;
  logic              cs_q_r,    cs_q_nxt;
  logic              rst_ev_r,  rst_ev_nxt;
  logic              done_r,    done_nxt;
  logic              cv_fall;
  logic              cs_fall;

  always_comb begin
    cv_fall    = cv_q_r & ~BUS.convst_n;
    cs_fall    = cs_q_r & ~BUS.cs_n;
    cv_q_nxt   = BUS.convst_n;
    cs_q_nxt   = BUS.cs_n;
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    hold_nxt   = hold_r;
    latch_nxt  = latch_r;
    trim_nxt   = trim_r;
    busy_nxt   = busy_r;
    rst_ev_nxt = 1'b0;
    case (st_r)
      CV_SAMPLE: begin
        if (cv_fall && !BUS.cs_n) begin
          hold_nxt = SAMPLE_I;
          busy_nxt = 1'b1;
          cnt_nxt  = CONV_CYC - 8'h01;
          st_nxt   = CV_CONVERT;
        end
      end
      CV_CONVERT: begin
        if ((cv_fall && !BUS.cs_n) || cs_fall) begin
          latch_nxt  = '0;
          busy_nxt   = 1'b0;
          rst_ev_nxt = 1'b1;
          st_nxt     = CV_SAMPLE;
        end else if (cnt_r == 8'h00) begin
          busy_nxt  = 1'b0;
          st_nxt    = CV_SAMPLE;
          if (trim_r == TRIM_CONVERSIONS[1:0]) begin
            latch_nxt = hold_r;
          end else begin
            latch_nxt = '0;
            trim_nxt  = trim_r + 2'h1;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: st_nxt = CV_SAMPLE;
    endcase
    if (!BUS.rd_n && !BUS.cs_n) begin
      data_nxt = BUS.byte_sel ? {8'h00, latch_r[15:8]} : latch_r;
    end else begin
      data_nxt = '0;
    end
    done_nxt = (trim_nxt == TRIM_CONVERSIONS[1:0]);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      st_r     <= CV_SAMPLE;
      cnt_r    <= 8'h00;
      hold_r   <= '0;
      latch_r  <= '0;
      data_r   <= '0;
      trim_r   <= 2'h0;
      busy_r   <= 1'b0;
      cv_q_r   <= 1'b1;
      cs_q_r   <= 1'b1;
      rst_ev_r <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      hold_r   <= hold_nxt;
      latch_r  <= latch_nxt;
      data_r   <= data_nxt;
      trim_r   <= trim_nxt;
      busy_r   <= busy_nxt;
      cv_q_r   <= cv_q_nxt;
      cs_q_r   <= cs_q_nxt;
      rst_ev_r <= rst_ev_nxt;
      done_r   <= done_nxt;
    end
  end

  assign BUS.busy      = busy_r;
  assign BUS.data      = data_r;
  assign TRIM_DONE_O   = done_r;
  assign RESET_EVENT_O = rst_ev_r;

endmodule
`default_nettype wire

// ---- rtl/apc_ctrl.sv ----
// capture controller end: rate timer, convert/read pin sequencing, ping-pong capture
`timescale 1ns/10ps
`default_nettype none
module apc_ctrl
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic               SYS_CLK_I,
  input  wire logic               RESET_N_I,
  // pins
  apc_if.ctrl                     BUS,
  // control
  input  wire logic               ENABLE_I,
  input  wire logic               PULSE_MODE_I,
  input  wire logic [15:0]        PERIOD_I,
  // sample stream
  output var  logic               OUT_VALID_O,
  input  wire logic               OUT_READY_I,
  output var  logic [DATA_W-1:0]  OUT_DATA_O,
  output var  logic               OUT_BUF_O,
  output var  logic [IDX_W-1:0]   OUT_INDEX_O,
  // status
  output var  logic               FIRST_READY_O,
  output var  logic               SECOND_READY_O,
  output var  logic               ALERT_O,
  output var  logic               TRIG_MISS_O,
  output var  logic               LATE_READ_O
);

  // timer state
  logic [1:0]   pre_r,   pre_nxt;
  logic [15:0]  tcnt_r,  tcnt_nxt;
  logic         tout_r,  tout_nxt;
  logic [1:0]   tpc_r,   tpc_nxt;
  logic         tick;
  logic         tev;
  logic [15:0]  per_m1;

  // pin sequencer state
  apc_run_st_t  run_r,     run_nxt;
  apc_seq_st_t  seq_r,     seq_nxt;
  logic [7:0]   cv_cnt_r,  cv_cnt_nxt;
  logic [7:0]   rd_cnt_r,  rd_cnt_nxt;
  logic [7:0]   win_r,     win_nxt;
  logic [7:0]   quiet_r,   quiet_nxt;
  logic         pend_r,    pend_nxt;
  logic         rd_pend_r, rd_pend_nxt;
  logic         convst_n_r, convst_n_nxt;
  logic         cs_n_r,    cs_n_nxt;
  logic         rd_n_r,    rd_n_nxt;
  logic         busy_q_r,  busy_q_nxt;
  logic         miss_r,    miss_nxt;
  logic         late_r,    late_nxt;
  logic         issue;
  logic         rd_start;
  logic         bz_rise;
  logic         cap;

  // capture state
  logic [2:0]        skip_r,  skip_nxt;
  logic [WCNT_W-1:0] wcnt_r,  wcnt_nxt;
  logic              frdy_r,  frdy_nxt;
  logic              srdy_r,  srdy_nxt;
  logic              alert_r, alert_nxt;
  logic              push;
  logic [ENTRY_W-1:0] push_word;

  // two-entry buffer state
  logic [ENTRY_W-1:0] mem_r [2];
  logic [ENTRY_W-1:0] mem_nxt [2];
  logic [ENTRY_W-1:0] head_r,  head_nxt;
  logic               wp_r,    wp_nxt;
  logic               rp_r,    rp_nxt;
  logic [1:0]         cnt_r,   cnt_nxt;
  logic               vld_r,   vld_nxt;
  logic               wr;
  logic               pop;

  // sample rate timer on a divide-by-four tick
  always_comb begin
    tick     = (pre_r == TIMER_DIV_LAST);
    per_m1   = (PERIOD_I == 16'h0000) ? 16'h0000 : PERIOD_I - 16'h0001;
    pre_nxt  = 2'h0;
    tcnt_nxt = tcnt_r;
    tout_nxt = tout_r;
    tpc_nxt  = tpc_r;
    tev      = 1'b0;
    if (run_r == RS_IDLE) begin
      tcnt_nxt = 16'h0000;
      tout_nxt = 1'b0;
      tpc_nxt  = 2'h0;
    end else begin
      pre_nxt = tick ? 2'h0 : pre_r + 2'h1;
      if (tick) begin
        if (tpc_r != 2'h0) begin
          tpc_nxt = tpc_r - 2'h1;
        end
        if (tcnt_r >= per_m1) begin
          tcnt_nxt = 16'h0000;
          if (PULSE_MODE_I) begin
            tpc_nxt = PULSE_TIMER_CLKS;
            tev     = 1'b1;
          end else begin
            tout_nxt = ~tout_r;
            tev      = ~tout_r;
          end
        end else begin
          tcnt_nxt = tcnt_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      pre_r  <= 2'h0;
      tcnt_r <= 16'h0000;
      tout_r <= 1'b0;
      tpc_r  <= 2'h0;
    end else begin
      pre_r  <= pre_nxt;
      tcnt_r <= tcnt_nxt;
      tout_r <= tout_nxt;
      tpc_r  <= tpc_nxt;
    end
  end

  // convert and read pin sequencing
  always_comb begin
    run_nxt      = ENABLE_I ? RS_RUN : RS_IDLE;
    bz_rise      = BUS.busy & ~busy_q_r;
    busy_q_nxt   = BUS.busy;
    seq_nxt      = seq_r;
    cv_cnt_nxt   = cv_cnt_r;
    rd_cnt_nxt   = rd_cnt_r;
    convst_n_nxt = convst_n_r;
    rd_n_nxt     = rd_n_r;
    cs_n_nxt     = 1'b0;
    miss_nxt     = miss_r;
    late_nxt     = late_r;
    issue        = 1'b0;
    rd_start     = 1'b0;
    cap          = 1'b0;
    win_nxt      = bz_rise ? 8'h00 : ((win_r == IO_WINDOW_CYC) ? win_r : win_r + 8'h01);
    if (run_r == RS_IDLE) begin
      seq_nxt      = SQ_IDLE;
      convst_n_nxt = 1'b1;
      rd_n_nxt     = 1'b1;
      cs_n_nxt     = 1'b1;
      miss_nxt     = 1'b0;
      late_nxt     = 1'b0;
      pend_nxt     = 1'b0;
      rd_pend_nxt  = 1'b0;
    end else begin
      if (PULSE_MODE_I) begin
        convst_n_nxt = (tpc_r == 2'h0);
        seq_nxt      = SQ_IDLE;
      end else begin
        case (seq_r)
          SQ_IDLE: begin
            // stall new conversions while the output buffer is full
            if (pend_r && !BUS.busy && rd_n_r && quiet_r >= QUIET_CYC &&
                cnt_r != FIFO_FULL) begin
              issue        = 1'b1;
              convst_n_nxt = 1'b0;
              cv_cnt_nxt   = CONVST_LOW_CYC - 8'h01;
              seq_nxt      = SQ_LOW;
            end
          end
          SQ_LOW: begin
            if (cv_cnt_r == 8'h00) begin
              convst_n_nxt = 1'b1;
              seq_nxt      = SQ_IDLE;
            end else begin
              cv_cnt_nxt = cv_cnt_r - 8'h01;
            end
          end
          default: seq_nxt = SQ_IDLE;
        endcase
      end
      pend_nxt = (tev & ~PULSE_MODE_I) | (pend_r & ~issue);
      if (tev && !PULSE_MODE_I && pend_r && !issue) begin
        miss_nxt = 1'b1;
      end
      if (rd_n_r) begin
        if (rd_pend_r) begin
          if (win_r + RD_LOW_CYC <= IO_WINDOW_CYC) begin
            rd_start   = 1'b1;
            rd_n_nxt   = 1'b0;
            rd_cnt_nxt = RD_LOW_CYC - 8'h01;
          end else begin
            late_nxt = 1'b1;
          end
        end
      end else if (rd_cnt_r == 8'h00) begin
        rd_n_nxt = 1'b1;
        cap      = 1'b1;
      end else begin
        rd_cnt_nxt = rd_cnt_r - 8'h01;
      end
      rd_pend_nxt = bz_rise | (rd_pend_r & rd_n_r & ~rd_start & ~late_nxt);
    end
    if (convst_n_nxt != convst_n_r || rd_n_nxt != rd_n_r || cs_n_nxt != cs_n_r) begin
      quiet_nxt = 8'h00;
    end else begin
      quiet_nxt = (quiet_r >= QUIET_CYC) ? quiet_r : quiet_r + 8'h01;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      run_r      <= RS_IDLE;
      seq_r      <= SQ_IDLE;
      cv_cnt_r   <= 8'h00;
      rd_cnt_r   <= 8'h00;
      win_r      <= 8'h00;
      quiet_r    <= 8'h00;
      pend_r     <= 1'b0;
      rd_pend_r  <= 1'b0;
      convst_n_r <= 1'b1;
      cs_n_r     <= 1'b1;
      rd_n_r     <= 1'b1;
      busy_q_r   <= 1'b0;
      miss_r     <= 1'b0;
      late_r     <= 1'b0;
    end else begin
      run_r      <= run_nxt;
      seq_r      <= seq_nxt;
      cv_cnt_r   <= cv_cnt_nxt;
      rd_cnt_r   <= rd_cnt_nxt;
      win_r      <= win_nxt;
      quiet_r    <= quiet_nxt;
      pend_r     <= pend_nxt;
      rd_pend_r  <= rd_pend_nxt;
      convst_n_r <= convst_n_nxt;
      cs_n_r     <= cs_n_nxt;
      rd_n_r     <= rd_n_nxt;
      busy_q_r   <= busy_q_nxt;
      miss_r     <= miss_nxt;
      late_r     <= late_nxt;
    end
  end

  // word routing into first buffer, second buffer or discard
  always_comb begin
    skip_nxt  = skip_r;
    wcnt_nxt  = wcnt_r;
    frdy_nxt  = frdy_r;
    srdy_nxt  = srdy_r;
    alert_nxt = 1'b0;
    push      = 1'b0;
    if (wcnt_r >= BUFFER_LENGTH) begin
      push_word = {1'b1, IDX_W'(wcnt_r - BUFFER_LENGTH), BUS.data};
    end else begin
      push_word = {1'b0, wcnt_r[IDX_W-1:0], BUS.data};
    end
    if (run_r == RS_IDLE) begin
      skip_nxt = 3'h0;
      wcnt_nxt = '0;
      frdy_nxt = 1'b0;
      srdy_nxt = 1'b0;
    end else if (cap) begin
      if (skip_r != DISCARD_LEAD) begin
        skip_nxt = skip_r + 3'h1;
      end else if (wcnt_r != CAPTURE_TOTAL) begin
        push     = 1'b1;
        wcnt_nxt = wcnt_r + 13'h0001;
        if (wcnt_r == SAMPLES_PER_BLOCK - 13'h0001) begin
          frdy_nxt  = 1'b1;
          alert_nxt = 1'b1;
        end
        if (wcnt_r == CAPTURE_TOTAL - 13'h0001) begin
          srdy_nxt  = 1'b1;
          alert_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      skip_r  <= 3'h0;
      wcnt_r  <= '0;
      frdy_r  <= 1'b0;
      srdy_r  <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      skip_r  <= skip_nxt;
      wcnt_r  <= wcnt_nxt;
      frdy_r  <= frdy_nxt;
      srdy_r  <= srdy_nxt;
      alert_r <= alert_nxt;
    end
  end

  // two-entry output buffer
  always_comb begin
    pop     = vld_r & OUT_READY_I;
    wr      = push & (cnt_r != FIFO_FULL);
    mem_nxt = mem_r;
    if (wr) begin
      mem_nxt[wp_r] = push_word;
    end
    wp_nxt   = wp_r ^ wr;
    rp_nxt   = rp_r ^ pop;
    cnt_nxt  = cnt_r + {1'b0, wr} - {1'b0, pop};
    head_nxt = mem_nxt[rp_nxt];
    vld_nxt  = (cnt_nxt != 2'h0);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < 2; i++) begin
        mem_r[i] <= '0;
      end
      head_r <= '0;
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      cnt_r  <= 2'h0;
      vld_r  <= 1'b0;
    end else begin
      mem_r  <= mem_nxt;
      head_r <= head_nxt;
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      vld_r  <= vld_nxt;
    end
  end

  assign BUS.convst_n   = convst_n_r;
  assign BUS.cs_n       = cs_n_r;
  assign BUS.rd_n       = rd_n_r;
  assign BUS.byte_sel   = 1'b0;
  assign OUT_VALID_O    = vld_r;
  assign OUT_DATA_O     = head_r[DATA_W-1:0];
  assign OUT_INDEX_O    = head_r[DATA_W +: IDX_W];
  assign OUT_BUF_O      = head_r[ENTRY_W-1];
  assign FIRST_READY_O  = frdy_r;
  assign SECOND_READY_O = srdy_r;
  assign ALERT_O        = alert_r;
  assign TRIG_MISS_O    = miss_r;
  assign LATE_READ_O    = late_r;

endmodule
`default_nettype wire

// ---- sim/apc_monitor.sv ----
// pin-level checker for the link between capture controller and converter
`timescale 1ns/10ps
`default_nettype none
module apc_monitor
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  // pins
  input  wire logic        convst_n,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        byte_sel,
  input  wire logic        busy,
  input  wire logic [15:0] data
);
  logic [7:0] quiet_r;
  logic [7:0] quiet_nxt;
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  logic       rd_q_r;
  logic       cv_q_r;

  // cycles since the last read or convert start pin change, and cycles busy has been high
  always_comb begin
    quiet_nxt = (quiet_r == 8'hff) ? quiet_r : quiet_r + 8'h01;
    if (rd_n != rd_q_r || convst_n != cv_q_r) begin
      quiet_nxt = 8'h00;
    end
    busy_cnt_nxt = 8'h00;
    if (busy) begin
      busy_cnt_nxt = (busy_cnt_r == 8'hff) ? busy_cnt_r : busy_cnt_r + 8'h01;
    end
  end

  // pins idle during reset, so the quiet count starts full
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      quiet_r    <= 8'hff;
      busy_cnt_r <= 8'h00;
      rd_q_r     <= 1'b1;
      cv_q_r     <= 1'b1;
    end else begin
      quiet_r    <= quiet_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      rd_q_r     <= rd_n;
      cv_q_r     <= convst_n;
    end
  end

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_byte_sel_low: assert property (byte_sel == 1'b0)
    else $error("byte select not low");
  a_convst_width: assert property ($fell(convst_n) |-> !convst_n [*4])
    else $error("convert start pulse too short");
  a_hold_on_convst: assert property ($fell(convst_n) && !cs_n && !busy |=> $rose(busy))
    else $error("busy did not follow convert start");
  a_conv_duration: assert property ($fell(busy) |-> busy_cnt_r == CONV_CYC)
    else $error("conversion length wrong");
  a_read_on_busy: assert property ($rose(busy) |-> ##2 $fell(rd_n))
    else $error("no read two cycles after busy rise");
  a_read_width: assert property ($fell(rd_n) |-> !rd_n [*4] ##1 rd_n)
    else $error("read strobe width wrong");
  a_quiet_zone: assert property ($fell(convst_n) |-> quiet_r >= QUIET_CYC - 8'h01)
    else $error("pin activity too close to convert start");
  a_read_window: assert property ($rose(rd_n) |-> busy && busy_cnt_r <= IO_WINDOW_CYC)
    else $error("read ends outside the early conversion window");
  a_no_cs_reset: assert property (busy |-> !$fell(cs_n))
    else $error("select fell during conversion");
  a_no_convst_reset: assert property (busy |-> !$fell(convst_n))
    else $error("convert start fell during conversion");

  cover property ($rose(busy) ##2 $fell(rd_n));
  cover property ($fell(convst_n) ##[100:400] $fell(convst_n));
  cover property ($fell(busy) ##[1:300] $fell(convst_n));
endmodule
`default_nettype wire

// ---- sim/tb_adc_pingpong_capture.sv ----
// testbench: controller and converter back to back, plus a converter driven directly
`timescale 1ns/10ps
`default_nettype none
module tb_adc_pingpong_capture
  import apc_pkg::*;
;
  typedef struct packed {
    logic        mode;
    logic [15:0] period;
    logic [15:0] gap;
    logic [7:0]  low;
  } apc_row_t;
  // clock mode gap is 8 x period, pulse mode gap 4 x period
  apc_row_t    rows [4] = '{'{1'b0, 16'h0014, 16'h00a0, 8'h04},
                            '{1'b0, 16'h0026, 16'h0130, 8'h04},
                            '{1'b1, 16'h0026, 16'h0098, 8'h08},
                            '{1'b1, 16'h0032, 16'h00c8, 8'h08}};
  logic        clk, rst_n, enable, pulse_mode, out_ready, out_valid, out_buf;
  logic        cv_q = 1'b1;
  logic        first_ready, second_ready, alert, trig_miss, late_read, trim_b, rst_ev_b;
  logic [15:0] period, sample_b, out_data, seen;
  logic [15:0] sample = 16'h1000;
  logic [10:0] out_index;
  logic [15:0] exp_q [$];
  int          failures = 0;
  int          num_checks = 0;
  int          cyc, fall_cnt, last_fall, prev_fall, last_low, ev_b_cnt, alerts, base, n;

  apc_if link();
  apc_if probe();

  apc_ctrl apc_ctrl_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .BUS(link), .ENABLE_I(enable),
    .PULSE_MODE_I(pulse_mode), .PERIOD_I(period), .OUT_VALID_O(out_valid),
    .OUT_READY_I(out_ready), .OUT_DATA_O(out_data), .OUT_BUF_O(out_buf),
    .OUT_INDEX_O(out_index), .FIRST_READY_O(first_ready), .SECOND_READY_O(second_ready),
    .ALERT_O(alert), .TRIG_MISS_O(trig_miss), .LATE_READ_O(late_read));
  apc_conv apc_conv_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .BUS(link), .SAMPLE_I(sample),
    .TRIM_DONE_O(), .RESET_EVENT_O());
  apc_conv apc_conv_b_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .BUS(probe),
    .SAMPLE_I(sample_b), .TRIM_DONE_O(trim_b), .RESET_EVENT_O(rst_ev_b));
  apc_monitor apc_monitor_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .convst_n(link.convst_n),
    .cs_n(link.cs_n), .rd_n(link.rd_n), .byte_sel(link.byte_sel), .busy(link.busy),
    .data(link.data));

  // new sample after each convert pulse; record what was held
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cv_q <= link.convst_n;
    ev_b_cnt <= ev_b_cnt + int'(rst_ev_b === 1'b1);
    alerts <= alerts + int'(alert === 1'b1);
    if (link.convst_n === 1'b0 && cv_q === 1'b1) begin
      fall_cnt <= fall_cnt + 1;
      prev_fall <= last_fall;
      last_fall <= cyc;
    end
    if (link.convst_n === 1'b1 && cv_q === 1'b0) begin
      last_low <= cyc - last_fall;
      exp_q.push_back(sample);
      sample <= sample + 16'h0101;
    end
  end

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic take(input int k);
    int w;
    w = 0;
    #1;
    while (out_valid !== 1'b1 && w < 400) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(out_data, exp_q[k + 3]);
    check(out_buf, 1'b0);
    check(out_index, 32'(k));
    @(posedge clk);
  endtask

  task automatic pconv();
    @(posedge clk);
    probe.convst_n <= 1'b0;
    tick(4);
    probe.convst_n <= 1'b1;
  endtask

  task automatic pread(output logic [15:0] v);
    @(posedge clk);
    probe.rd_n <= 1'b0;
    tick(3);
    #1;
    v = probe.data;
    @(posedge clk);
    probe.rd_n <= 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    conclude();
  end

  initial begin
    {rst_n, enable, pulse_mode, out_ready} = 4'h0;
    period = 16'h0014;
    sample_b = 16'h5a5a;
    {probe.convst_n, probe.cs_n, probe.rd_n, probe.byte_sel} = 4'he;
    tick(6);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check({link.convst_n, link.cs_n, link.rd_n, out_valid, first_ready, alert}, 6'h38);
    // ordinary rates and pulse widths
    foreach (rows[r]) begin
      @(posedge clk);
      out_ready <= 1'b1;
      pulse_mode <= rows[r].mode;
      period <= rows[r].period;
      enable <= 1'b1;
      base = fall_cnt;
      for (n = 0; n < 3000 && fall_cnt < base + 3; n++) @(posedge clk);
      #1;
      check(32'(last_fall - prev_fall), 32'(rows[r].gap));
      check(32'(last_low), 32'(rows[r].low));
      check({trig_miss, late_read}, 2'h0);
      // let the running read and convert pulse end before disabling
      tick(9);
      enable <= 1'b0;
      tick(150);
      #1;
      check(link.cs_n, 1'b1);
    end
    // capture: reads dropped at start, receiver stall fills buffer, then drain
    @(posedge clk);
    out_ready <= 1'b0;
    pulse_mode <= 1'b0;
    period <= 16'h0014;
    exp_q.delete();
    enable <= 1'b1;
    tick(1400);
    #1;
    check(exp_q.size(), 32'h6);
    check(out_valid, 1'b1);
    check(trig_miss, 1'b1);
    @(posedge clk);
    out_ready <= 1'b1;
    for (int k = 0; k < 12; k++) take(k);
    // second reset in mid-run
    rst_n <= 1'b0;
    tick(2);
    #1;
    check({link.convst_n, link.cs_n, out_valid, first_ready, second_ready}, 5'h18);
    check(alerts, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    enable <= 1'b0;
    // directly driven converter: trim results, then both internal reset paths
    probe.cs_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      pconv();
      tick(110);
      pread(seen);
      check(seen, (i < 3) ? 16'h0000 : sample_b);
    end
    check(trim_b, 1'b1);
    pconv();
    tick(10);
    pconv();
    #1;
    check({probe.busy, 4'(ev_b_cnt)}, 5'h01);
    pread(seen);
    check(seen, 16'h0000);
    pconv();
    tick(10);
    probe.cs_n <= 1'b1;
    tick(1);
    probe.cs_n <= 1'b0;
    tick(3);
    #1;
    check({probe.busy, 4'(ev_b_cnt)}, 5'h02);
    pconv();
    tick(110);
    pread(seen);
    check(seen, sample_b);
    conclude();
  end
endmodule
`default_nettype wire
